// *** bench/iobd_decode_checker.sv ***
// port assertions for the base address decoder
module iobd_decode_checker
  import iobd_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic [1:0]   config_port_strap,
  input wire logic         cfg_enter,
  input wire logic         cfg_exit,
  input wire iobd_io_req_t io_req,
  input wire logic [7:0]   io_rdata,
  input wire logic         io_claim,
  input wire iobd_sel_t    dev_sel,
  input wire logic [2:0]   dev_reg_offset,
  input wire logic [7:0]   uart_ir_power_control,
  input wire logic         dock_switch_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  offset_follow_a: assert property (dev_reg_offset == io_req.addr[2:0])
    else $error("register offset differs from address");
  sel_claims_a: assert property ((|dev_sel) |-> io_claim)
    else $error("target selected without claim");
  switch_dock_a: assert property (dock_switch_sel |-> dev_sel.dock)
    else $error("switch select outside docking window");
  ser_range_a: assert property ((dev_sel.ser1 || dev_sel.ser2)
    |-> io_req.addr >= 16'h0100 && io_req.addr <= 16'h03ff)
    else $error("serial select outside serial range");
  rt_range_a: assert property (dev_sel.runtime |-> io_req.addr <= 16'h0fff)
    else $error("runtime select above runtime range");
  pwr_hold_a: assert property (!(io_req.valid && io_req.write)
    |=> $stable(uart_ir_power_control))
    else $error("power byte changed without a write");
  rdata_hold_a: assert property (!(io_req.valid && !io_req.write) |=> $stable(io_rdata))
    else $error("read data changed without a read");
  reset_zero_a: assert property ($rose(reset_n)
    |-> io_rdata == 8'h00 && uart_ir_power_control == 8'h00)
    else $error("registers not cleared by reset");
endmodule

// *** bench/iobd_decode_test.sv ***
// testbench for the base address decoder
module iobd_decode_test
  import iobd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         cfg_enter = 1'b0;
  logic         cfg_exit = 1'b0;
  logic [1:0]   strap = 2'b10;
  logic [15:0]  cfg = 16'h162e;
  logic [7:0]   rdata, pwr, h;
  logic [2:0]   offs;
  logic         claim, sw;
  iobd_io_req_t io_req;
  iobd_sel_t    sel;
  int           err_count = 0;
  int           n_compared = 0;
  always #2.5 clk = ~clk;
  iobd_decode DUT(.clk(clk), .reset_n(reset_n), .config_port_strap(strap),
    .cfg_enter(cfg_enter), .cfg_exit(cfg_exit), .io_req(io_req), .io_rdata(rdata),
    .io_claim(claim), .dev_sel(sel), .dev_reg_offset(offs),
    .uart_ir_power_control(pwr), .dock_switch_sel(sw));
  iobd_host HOST(.clk(clk), .io_req(io_req), .io_rdata(rdata), .io_claim(claim),
    .dev_sel(sel), .dock_switch_sel(sw), .dev_reg_offset(offs));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // index then data, as two separate host cycles
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    HOST.cyc(1'b1, cfg, i, h);
    HOST.cyc(1'b1, cfg + 16'h0001, d, h);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input string n);
    HOST.cyc(1'b1, cfg, i, h);
    HOST.cyc(1'b0, cfg + 16'h0001, 8'h00, h);
    chk(n, e, rdata);
  endtask
  // hit byte packs claim, four selects and the switch select
  task automatic probe(input logic [15:0] a, input logic [7:0] e, input string n);
    HOST.cyc(1'b0, a, 8'h00, h);
    chk(n, e, h);
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // whole run is about 130 cycles; this limit only catches a hang
  initial begin
    #20000;
    err_count++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    @(negedge clk) cfg_enter = 1'b1;
    @(negedge clk) cfg_enter = 1'b0;
    rd(8'h3b, 8'h00, "dock high reset");
    rd(8'h3c, 8'h00, "dock low reset");
    rd(8'h3a, 8'h00, "activate reset");
    wr(8'h3a, 8'h00);
    wr(8'h3b, 8'h12);
    wr(8'h3c, 8'h34);
    rd(8'h3b, 8'h12, "dock high");
    rd(8'h3c, 8'h34, "dock low");
    probe(16'h1234, 8'h00, "dock inactive");
    wr(8'h3a, 8'hf8);
    probe(16'h1234, 8'h23, "dock hit");
    rd(8'h3a, 8'h08, "activate read");
    probe(16'h0234, 8'h00, "dock alias");
    wr(8'h24, 8'hfe);
    probe(16'h03fd, 8'h30, "serial hit");
    chk("serial offset", 8'h05, {5'h00, HOST.seen_off});
    probe(16'h03f0, 8'h00, "serial miss");
    wr(8'h02, 8'hff);
    chk("power byte", 8'hff, pwr);
    probe(16'h03fd, 8'h30, "powered down hit");
    wr(8'h3a, 8'h00);
    probe(16'h1234, 8'h00, "deactivated");
    // runtime block at 0x0420, claimed only once its activate bit is set
    wr(8'h30, 8'h04);
    wr(8'h21, 8'h20);
    probe(16'h042f, 8'h00, "runtime inactive");
    wr(8'h3a, 8'h02);
    probe(16'h042f, 8'h24, "runtime hit");
    probe(16'h0430, 8'h00, "runtime miss");
    wr(8'h13, 8'h00);
    cfg = 16'h002e;
    wr(8'h12, 8'h4e);
    cfg = 16'h004e;
    rd(8'h3b, 8'h12, "relocated port");
    probe(16'h162e, 8'h00, "old port");
    @(negedge clk) cfg_exit = 1'b1;
    @(negedge clk) cfg_exit = 1'b0;
    probe(16'h004e, 8'h00, "closed port");
    // second reset with another strap: registers clear and the port moves
    @(negedge clk) begin
      reset_n = 1'b0;
      strap = 2'b11;
    end
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk) cfg_enter = 1'b1;
    @(negedge clk) cfg_enter = 1'b0;
    cfg = 16'h164e;
    chk("power after reset", 8'h00, pwr);
    rd(8'h3b, 8'h00, "dock high after reset");
    rd(8'h3c, 8'h00, "dock low after reset");
    rd(8'h13, 8'h16, "strapped port high");
    stop_test;
  end
endmodule
bind iobd_decode iobd_decode_checker CHK(.clk(clk), .reset_n(reset_n),
  .config_port_strap(config_port_strap), .cfg_enter(cfg_enter), .cfg_exit(cfg_exit),
  .io_req(io_req), .io_rdata(io_rdata), .io_claim(io_claim), .dev_sel(dev_sel),
  .dev_reg_offset(dev_reg_offset), .uart_ir_power_control(uart_ir_power_control),
  .dock_switch_sel(dock_switch_sel));

// *** bench/iobd_host.sv ***
// host model issuing single I/O cycles to the decoder
module iobd_host
  import iobd_pkg::*;
(
  input  wire logic         clk,
  output iobd_io_req_t      io_req,
  input  wire logic [7:0]   io_rdata,
  input  wire logic         io_claim,
  input  wire iobd_sel_t    dev_sel,
  input  wire logic         dock_switch_sel,
  input  wire logic [2:0]   dev_reg_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] seen_off;
  initial io_req = '0;
  // one cycle per call; an idle bus shows inverted leftovers, never a stale copy
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] hit);
    @(negedge clk);
    io_req = '{1'b1, w, a, d};
    #1 hit = {2'b00, io_claim, dev_sel, dock_switch_sel};
    seen_off = dev_reg_offset;
    @(negedge clk);
    io_req = '{1'b0, w, ~a, ~d};
  endtask
endmodule

// *** hw/iobd_decode.sv ***
// configuration port, base registers and I/O address decode
// What this block does
// - dock_base_high_byte holds base bits 15..8, read/write, zero after reset.
// - dock_base_low_byte holds base bits 7..0, read/write, zero after reset.
// - docking base is unaligned; only offset zero selects switch control register.
// - serial bases 8-byte aligned within range; offsets 0..7 select uart registers.
// - index port at configuration address, data port at address plus one.
// - strap picks one of four config addresses; relocation registers move it.
// - power-control bit disables device pins but not its address decode.
// - powered-down but activated devices still join range checking.
// - activate bit 3 enables docking decode; clear by default.
// - docking decode compares all sixteen address bits.
// - docking base registers reachable only in config state with matching index.
`include "iobd_defs.svh"
module iobd_decode
  import iobd_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [1:0]   config_port_strap,
  input  wire logic         cfg_enter,
  input  wire logic         cfg_exit,
  input  wire iobd_io_req_t io_req,
  output logic [7:0]        io_rdata,
  output logic              io_claim,
  output iobd_sel_t         dev_sel,
  output logic [2:0]        dev_reg_offset,
  output logic [7:0]        uart_ir_power_control,
  output logic              dock_switch_sel
);

  logic        strap_done_r, strap_done_nxt;
  logic        cfg_state_r, cfg_state_nxt;
  logic [7:0]  config_index_register_r, idx_nxt;
  logic [7:0]  reloc_lo_r, reloc_lo_nxt, reloc_hi_r, reloc_hi_nxt;
  logic [7:0]  logical_device_activate_r, act_nxt;
  logic [7:0]  pwr_r, pwr_nxt;
  logic [7:0]  ser1_r, ser1_nxt, ser2_r, ser2_nxt;
  logic [7:0]  rt_hi_r, rt_hi_nxt, rt_lo_r, rt_lo_nxt;
  logic [7:0]  dock_base_high_byte_r, dock_hi_nxt;
  logic [7:0]  dock_base_low_byte_r, dock_lo_nxt;
  logic [7:0]  rdata_nxt, io_rdata_r;
  logic [15:0] cfg_addr, ser1_base, ser2_base, rt_base, dock_base;
  logic        hit_idx, hit_data, wr_data;
  logic        ser1_hit, ser2_hit, rt_hit, dock_hit;

  // base addresses taken straight from the registers, no pipeline stage
  assign cfg_addr  = {reloc_hi_r, reloc_lo_r[7:1], 1'b0};
  // serial byte holds base bits 9..2; bit 0 is base bit 2, forced low to keep 8-byte steps
  assign ser1_base = {6'h00, ser1_r[7:1], 1'b0, 2'h0};
  assign ser2_base = {6'h00, ser2_r[7:1], 1'b0, 2'h0};
  // runtime block sits on 16-byte steps, so its low nibble is always zero
  assign rt_base   = {4'h0, rt_hi_r[3:0], rt_lo_r[7:4], 4'h0};
  assign dock_base = {dock_base_high_byte_r, dock_base_low_byte_r};

  // index and data port hits; config state gates everything
  // no upper limit is checked on the port address: the strapped high addresses need none
  assign hit_idx  = io_req.valid && cfg_state_r && io_req.addr == cfg_addr;
  assign hit_data = io_req.valid && cfg_state_r && io_req.addr == cfg_addr + 16'h0001;
  assign wr_data  = hit_data && io_req.write;

  // runtime decode: activate gates the runtime and docking ranges, base range the serial ones; power bits never do
  always_comb begin
    ser1_hit = io_req.valid && ser1_base >= `IOBD_SER_LO && ser1_base <= `IOBD_SER_HI
               && io_req.addr[15:3] == ser1_base[15:3];
    ser2_hit = io_req.valid && ser2_base >= `IOBD_SER_LO && ser2_base <= `IOBD_SER_HI
               && io_req.addr[15:3] == ser2_base[15:3];
    // sixteen-byte runtime window, so only address bits 15..4 compare
    rt_hit   = io_req.valid && logical_device_activate_r[`IOBD_ACT_RT_BIT]
               && io_req.addr[15:4] == rt_base[15:4];
    // only offset zero of the docking block exists
    dock_hit = io_req.valid && logical_device_activate_r[`IOBD_ACT_DOCK_BIT]
               && io_req.addr == dock_base;
  end

  // claim and selects; serial ports have no activate bit here, so base range gates them
  // config port hits claim too, otherwise the host would see the index port float
  always_comb begin
    dev_sel.ser1    = ser1_hit;
    dev_sel.ser2    = ser2_hit;
    dev_sel.runtime = rt_hit;
    dev_sel.dock    = dock_hit;
    dev_reg_offset  = io_req.addr[2:0];
    dock_switch_sel = dock_hit;
    io_claim        = hit_idx || hit_data || ser1_hit || ser2_hit || rt_hit || dock_hit;
  end

  // next values of configuration state and registers
  always_comb begin
    strap_done_nxt = 1'b1;
    cfg_state_nxt  = cfg_enter ? 1'b1 : (cfg_exit ? 1'b0 : cfg_state_r);
    idx_nxt        = config_index_register_r;
    reloc_lo_nxt   = reloc_lo_r;
    reloc_hi_nxt   = reloc_hi_r;
    act_nxt        = logical_device_activate_r;
    pwr_nxt        = pwr_r;
    ser1_nxt       = ser1_r;
    ser2_nxt       = ser2_r;
    rt_hi_nxt      = rt_hi_r;
    rt_lo_nxt      = rt_lo_r;
    dock_hi_nxt    = dock_base_high_byte_r;
    dock_lo_nxt    = dock_base_low_byte_r;
    // strap caught once on the first clock after reset release
    // a host cycle in that same clock is lost, hence no request before the second edge
    if (!strap_done_r) begin
      case (config_port_strap)
        2'd0: {reloc_hi_nxt, reloc_lo_nxt} = `IOBD_CFG_ADDR0;
        2'd1: {reloc_hi_nxt, reloc_lo_nxt} = `IOBD_CFG_ADDR1;
        2'd2: {reloc_hi_nxt, reloc_lo_nxt} = `IOBD_CFG_ADDR2;
        default: {reloc_hi_nxt, reloc_lo_nxt} = `IOBD_CFG_ADDR3;
      endcase
    end else if (hit_idx && io_req.write) begin
      idx_nxt = io_req.wdata;
    end else if (wr_data) begin
      // writes to an unknown index fall through and change nothing
      if (config_index_register_r == `IOBD_IDX_RELOC_LO) begin
        reloc_lo_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_RELOC_HI) begin
        reloc_hi_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_ACT) begin
        act_nxt = io_req.wdata & `IOBD_ACT_MASK;
      end else if (config_index_register_r == `IOBD_IDX_PWR) begin
        pwr_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_SER1) begin
        ser1_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_SER2) begin
        ser2_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_RT_HI) begin
        rt_hi_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_RT_LO) begin
        rt_lo_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_DOCK_HI) begin
        dock_hi_nxt = io_req.wdata;
      end else if (config_index_register_r == `IOBD_IDX_DOCK_LO) begin
        dock_lo_nxt = io_req.wdata;
      end
    end
  end

  // read data: index port returns index, data port the indexed register
  // data stands until the next config-port read, so the host may take it late
  always_comb begin
    rdata_nxt = io_rdata_r;
    if (hit_idx && !io_req.write) begin
      rdata_nxt = config_index_register_r;
    end else if (hit_data && !io_req.write) begin
      if (config_index_register_r == `IOBD_IDX_RELOC_LO) begin
        rdata_nxt = reloc_lo_r;
      end else if (config_index_register_r == `IOBD_IDX_RELOC_HI) begin
        rdata_nxt = reloc_hi_r;
      end else if (config_index_register_r == `IOBD_IDX_ACT) begin
        rdata_nxt = logical_device_activate_r;
      end else if (config_index_register_r == `IOBD_IDX_PWR) begin
        rdata_nxt = pwr_r;
      end else if (config_index_register_r == `IOBD_IDX_SER1) begin
        rdata_nxt = ser1_r;
      end else if (config_index_register_r == `IOBD_IDX_SER2) begin
        rdata_nxt = ser2_r;
      end else if (config_index_register_r == `IOBD_IDX_RT_HI) begin
        rdata_nxt = rt_hi_r;
      end else if (config_index_register_r == `IOBD_IDX_RT_LO) begin
        rdata_nxt = rt_lo_r;
      end else if (config_index_register_r == `IOBD_IDX_DOCK_HI) begin
        rdata_nxt = dock_base_high_byte_r;
      end else if (config_index_register_r == `IOBD_IDX_DOCK_LO) begin
        rdata_nxt = dock_base_low_byte_r;
      end else begin
        rdata_nxt = `IOBD_RST_BYTE; // unmapped index reads zero
      end
    end
  end

  // registers; asynchronous reset loads constants only
  // strap_done_r low in reset makes the first edge after release load the strap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_r              <= 1'b0;
      cfg_state_r               <= 1'b0;
      config_index_register_r   <= `IOBD_RST_BYTE;
      reloc_lo_r                <= 8'(`IOBD_CFG_ADDR0);
      reloc_hi_r                <= `IOBD_RST_BYTE;
      logical_device_activate_r <= `IOBD_RST_BYTE;
      pwr_r                     <= `IOBD_RST_BYTE;
      ser1_r                    <= `IOBD_RST_BYTE;
      ser2_r                    <= `IOBD_RST_BYTE;
      rt_hi_r                   <= `IOBD_RST_BYTE;
      rt_lo_r                   <= `IOBD_RST_BYTE;
      dock_base_high_byte_r     <= `IOBD_RST_BYTE;
      dock_base_low_byte_r      <= `IOBD_RST_BYTE;
    end else begin
      strap_done_r              <= strap_done_nxt;
      cfg_state_r               <= cfg_state_nxt;
      config_index_register_r   <= idx_nxt;
      reloc_lo_r                <= reloc_lo_nxt;
      reloc_hi_r                <= reloc_hi_nxt;
      logical_device_activate_r <= act_nxt;
      pwr_r                     <= pwr_nxt;
      ser1_r                    <= ser1_nxt;
      ser2_r                    <= ser2_nxt;
      rt_hi_r                   <= rt_hi_nxt;
      rt_lo_r                   <= rt_lo_nxt;
      dock_base_high_byte_r     <= dock_hi_nxt;
      dock_base_low_byte_r      <= dock_lo_nxt;
    end
  end

  // read data register, kept apart from the bank so its hold logic stays local
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_r <= `IOBD_RST_BYTE;
    end else begin
      io_rdata_r <= rdata_nxt;
    end
  end

  assign io_rdata              = io_rdata_r;
  assign uart_ir_power_control = pwr_r;

endmodule

// *** hw/iobd_defs.svh ***
// offsets, indices, reset values and fixed addresses of the base decoder
`ifndef IOBD_DEFS_SVH
`define IOBD_DEFS_SVH
`define IOBD_IDX_PWR       8'h02
`define IOBD_IDX_RELOC_LO  8'h12
`define IOBD_IDX_RELOC_HI  8'h13
`define IOBD_IDX_SER1      8'h24
`define IOBD_IDX_SER2      8'h25
`define IOBD_IDX_RT_HI     8'h30
`define IOBD_IDX_RT_LO     8'h21
`define IOBD_IDX_ACT       8'h3a
`define IOBD_IDX_DOCK_HI   8'h3b
`define IOBD_IDX_DOCK_LO   8'h3c
`define IOBD_ACT_RT_BIT    1
`define IOBD_ACT_DOCK_BIT  3
`define IOBD_ACT_MASK      8'h0f
`define IOBD_RST_BYTE      8'h00
`define IOBD_CFG_ADDR0     16'h002e
`define IOBD_CFG_ADDR1     16'h004e
`define IOBD_CFG_ADDR2     16'h162e
`define IOBD_CFG_ADDR3     16'h164e
`define IOBD_SER_LO        16'h0100
`define IOBD_SER_HI        16'h03f8
`define IOBD_RT_HI_LIM     16'h0ff0
`define IOBD_CFG_HI_LIM    16'h07fe
`endif

// *** hw/iobd_pkg.sv ***
// types shared by the base address decoder
package iobd_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iobd_io_req_t;
  typedef struct packed {
    logic ser1;
    logic ser2;
    logic runtime;
    logic dock;
  } iobd_sel_t;
endpackage
